// ==== rtl/sat_tdm_cfg.svh ====
// Register map, reset values and field positions of the satellite TDM sync control
`ifndef SAT_TDM_CFG_SVH
`define SAT_TDM_CFG_SVH

`define ADDR_W 10
`define OFS_BLOCK_ENABLE 10'h200
`define OFS_SYNC_CTRL 10'h204
`define OFS_PRE_WIN_LEN 10'h205
`define OFS_PRE_THR 10'h206
`define OFS_SYNC_WIN_LEN 10'h207
`define OFS_PRESYNC_THR 10'h208
`define OFS_SYNC_THR 10'h209
`define OFS_SYNC_STATUS 10'h220

`define RST_BLOCK_ENABLE 8'hFF
`define RST_SYNC_CTRL 5'h10
`define RST_PRE_WIN_LEN 4'hF
`define RST_PRE_THR 7'h44
`define RST_SYNC_WIN_LEN 4'h3
`define RST_PRESYNC_THR 4'h2
`define RST_SYNC_THR 4'hB

// Enable register fields
`define EN_SECOND_FIFO 7
`define EN_SECOND_DESCR 6
`define EN_SECOND_METRIC 5
`define EN_SECOND_SYNC 4
`define EN_FIRST_FIFO 3
`define EN_FIRST_DESCR 2
`define EN_FIRST_METRIC 1
`define EN_FIRST_SYNC 0

// Sync control register fields
`define SC_FALLBACK 4
`define SC_INV_OUT 3
`define SC_INV_IN 2
`define SC_SWAP_OUT 1
`define SC_SWAP_IN 0

`define BUF_DEPTH 2

`endif

// ==== rtl/sat_tdm_pkg.sv ====
// Types shared by the satellite TDM sync control
`default_nettype none
package sat_tdm_pkg;
   typedef enum logic [0:0] {ST_ACQUIRE, ST_TRACK} sync_state_t;
endpackage : sat_tdm_pkg
`default_nettype wire

// ==== rtl/sat_tdm_frame_sync_control.sv ====
// Satellite TDM decoding control and satellite-one frame preamble synchronizer
// Function
// - Enable bits 7..4 gate satellite-two FIFO, descramble, metric, sync; reset all set.
// - Enable bits 3..0 gate satellite-one FIFO, descramble, metric and sync sub-blocks.
// - Once locked, preamble searched only in window around predicted position; reset 0F.
// - Preamble detected when correlation is at or above 7-bit threshold, reset 44.
// - Sync status judged over a window of predicted positions, length reset 03.
// - Misses in evaluation window reaching threshold (reset 02) restart full-stream acquisition.
// - Pre-sync loss threshold zero disables loss of lock from window misses.
// - Consecutive misses reaching long-dropout threshold (reset 0B) restart acquisition.
`include "sat_tdm_cfg.svh"
`default_nettype none
module sat_tdm_frame_sync_control
   import sat_tdm_pkg::*;
#(
   parameter int SYM_W = 8,
   parameter int FRAME_LEN = 64,
   parameter int POS_W = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Host register port
   input wire logic [`ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Soft-symbol stream from the demodulator
   input wire logic sym_valid,
   output logic sym_ready,
   input wire logic [SYM_W-1:0] sym_i,
   input wire logic [SYM_W-1:0] sym_q,
   input wire logic [6:0] sym_corr,
   // Synchronized stream out
   output logic out_valid,
   input wire logic out_ready,
   output logic [SYM_W-1:0] out_i,
   output logic [SYM_W-1:0] out_q,
   output logic out_frame_preamble,
   // Sub-block enables and status
   output logic second_fifo_mgmt_enable,
   output logic second_descramble_enable,
   output logic second_metric_gen_enable,
   output logic second_sync_enable,
   output logic first_fifo_mgmt_enable,
   output logic first_descramble_enable,
   output logic first_metric_gen_enable,
   output logic first_sync_enable,
   output logic sync_locked
);
   localparam int BW = 2 * SYM_W + 1;
   // ==========================================================
   // Register file
   logic [7:0] enable_r, enable_nxt;
   logic [4:0] ctrl_r, ctrl_nxt;
   logic [3:0] pwin_r, pwin_nxt;
   logic [6:0] pthr_r, pthr_nxt;
   logic [3:0] swin_r, swin_nxt;
   logic [3:0] psthr_r, psthr_nxt;
   logic [3:0] sthr_r, sthr_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   sync_state_t state_r, state_nxt;
   logic [3:0] consec_r, consec_nxt;
   logic [3:0] wmiss_r, wmiss_nxt;
   always_comb begin
      enable_nxt = enable_r;
      ctrl_nxt = ctrl_r;
      pwin_nxt = pwin_r;
      pthr_nxt = pthr_r;
      swin_nxt = swin_r;
      psthr_nxt = psthr_r;
      sthr_nxt = sthr_r;
      rdata_nxt = rdata_r;
      if (reg_wr) begin
         unique case (reg_addr)
            `OFS_BLOCK_ENABLE: enable_nxt = reg_wdata;
            `OFS_SYNC_CTRL: ctrl_nxt = reg_wdata[4:0];
            `OFS_PRE_WIN_LEN: pwin_nxt = reg_wdata[3:0];
            `OFS_PRE_THR: pthr_nxt = reg_wdata[6:0];
            `OFS_SYNC_WIN_LEN: swin_nxt = reg_wdata[3:0];
            `OFS_PRESYNC_THR: psthr_nxt = reg_wdata[3:0];
            `OFS_SYNC_THR: sthr_nxt = reg_wdata[3:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `OFS_BLOCK_ENABLE: rdata_nxt = enable_r;
            `OFS_SYNC_CTRL: rdata_nxt = {3'h0, ctrl_r};
            `OFS_PRE_WIN_LEN: rdata_nxt = {4'h0, pwin_r};
            `OFS_PRE_THR: rdata_nxt = {1'h0, pthr_r};
            `OFS_SYNC_WIN_LEN: rdata_nxt = {4'h0, swin_r};
            `OFS_PRESYNC_THR: rdata_nxt = {4'h0, psthr_r};
            `OFS_SYNC_THR: rdata_nxt = {4'h0, sthr_r};
            `OFS_SYNC_STATUS: rdata_nxt = {wmiss_r, consec_r[2:0], state_r == ST_TRACK};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         enable_r <= `RST_BLOCK_ENABLE;
         ctrl_r <= `RST_SYNC_CTRL;
         pwin_r <= `RST_PRE_WIN_LEN;
         pthr_r <= `RST_PRE_THR;
         swin_r <= `RST_SYNC_WIN_LEN;
         psthr_r <= `RST_PRESYNC_THR;
         sthr_r <= `RST_SYNC_THR;
         rdata_r <= 8'h00;
      end else begin
         enable_r <= enable_nxt;
         ctrl_r <= ctrl_nxt;
         pwin_r <= pwin_nxt;
         pthr_r <= pthr_nxt;
         swin_r <= swin_nxt;
         psthr_r <= psthr_nxt;
         sthr_r <= sthr_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata = rdata_r;
   assign second_fifo_mgmt_enable = enable_r[`EN_SECOND_FIFO];
   assign second_descramble_enable = enable_r[`EN_SECOND_DESCR];
   assign second_metric_gen_enable = enable_r[`EN_SECOND_METRIC];
   assign second_sync_enable = enable_r[`EN_SECOND_SYNC];
   assign first_fifo_mgmt_enable = enable_r[`EN_FIRST_FIFO];
   assign first_descramble_enable = enable_r[`EN_FIRST_DESCR];
   assign first_metric_gen_enable = enable_r[`EN_FIRST_METRIC];
   assign first_sync_enable = enable_r[`EN_FIRST_SYNC];
   // ==========================================================
   // Preamble synchronizer
   logic [POS_W-1:0] pos_r, pos_nxt;
   logic hit_r, hit_nxt;
   logic [3:0] eval_r, eval_nxt;
   logic take, detect, in_window, close_win, missed, lose, mark;
   logic [POS_W-1:0] win_ext, far_edge;
   assign take = sym_valid && sym_ready;
   assign detect = sym_corr >= pthr_r;
   assign win_ext = POS_W'(pwin_r);
   assign far_edge = POS_W'(FRAME_LEN) - win_ext;
   assign in_window = (pos_r <= win_ext) || (pos_r >= far_edge);
   assign close_win = pos_r == win_ext + POS_W'(1);
   assign missed = close_win && !hit_r;
   always_comb begin
      state_nxt = state_r;
      pos_nxt = pos_r;
      hit_nxt = hit_r;
      eval_nxt = eval_r;
      consec_nxt = consec_r;
      wmiss_nxt = wmiss_r;
      lose = 1'b0;
      mark = 1'b0;
      if (take) begin
         pos_nxt = (pos_r == POS_W'(FRAME_LEN - 1)) ? '0 : pos_r + POS_W'(1);
         unique case (state_r)
            ST_ACQUIRE: begin
               // Full-stream search
               if (detect) begin
                  state_nxt = ST_TRACK;
                  mark = 1'b1;
                  pos_nxt = POS_W'(1);
                  hit_nxt = 1'b1;
                  eval_nxt = 4'h0;
                  consec_nxt = 4'h0;
                  wmiss_nxt = 4'h0;
               end
            end
            ST_TRACK: begin
               if (detect && in_window && !hit_r) begin
                  mark = 1'b1;
                  pos_nxt = POS_W'(1);
                  hit_nxt = 1'b1;
               end else if (close_win) begin
                  hit_nxt = 1'b0;
                  consec_nxt = missed ? consec_r + 4'h1 : 4'h0;
                  if (eval_r + 4'h1 >= swin_r) begin
                     eval_nxt = 4'h0;
                     wmiss_nxt = 4'h0;
                  end else begin
                     eval_nxt = eval_r + 4'h1;
                     wmiss_nxt = wmiss_r + {3'h0, missed};
                  end
                  // Window-miss loss, disabled by zero threshold
                  if (missed && psthr_r != 4'h0 && wmiss_r + 4'h1 >= psthr_r) begin
                     lose = 1'b1;
                  end
                  if (missed && consec_r + 4'h1 >= sthr_r) begin
                     lose = 1'b1;
                  end
                  if (lose && ctrl_r[`SC_FALLBACK]) begin
                     state_nxt = ST_ACQUIRE;
                  end
               end
            end
         endcase
      end
      if (!enable_r[`EN_FIRST_SYNC]) begin
         state_nxt = ST_ACQUIRE;
         mark = 1'b0;
         hit_nxt = 1'b0;
         eval_nxt = 4'h0;
         consec_nxt = 4'h0;
         wmiss_nxt = 4'h0;
      end
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         state_r <= ST_ACQUIRE;
         pos_r <= '0;
         hit_r <= 1'b0;
         eval_r <= 4'h0;
         consec_r <= 4'h0;
         wmiss_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         pos_r <= pos_nxt;
         hit_r <= hit_nxt;
         eval_r <= eval_nxt;
         consec_r <= consec_nxt;
         wmiss_r <= wmiss_nxt;
      end
   end
   assign sync_locked = (state_r == ST_TRACK) && enable_r[`EN_FIRST_SYNC];
   // ==========================================================
   // Data conditioning and two-entry output buffer
   logic [SYM_W-1:0] ci, cq, oi, oq;
   logic [BW-1:0] mem_r [`BUF_DEPTH];
   logic [BW-1:0] mem_nxt [`BUF_DEPTH];
   logic wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic pop;
   always_comb begin
      ci = ctrl_r[`SC_SWAP_IN] ? sym_q : sym_i;
      cq = ctrl_r[`SC_SWAP_IN] ? sym_i : sym_q;
      if (ctrl_r[`SC_INV_IN]) begin
         ci = ~ci;
         cq = ~cq;
      end
      oi = ctrl_r[`SC_SWAP_OUT] ? cq : ci;
      oq = ctrl_r[`SC_SWAP_OUT] ? ci : cq;
      if (ctrl_r[`SC_INV_OUT]) begin
         oi = ~oi;
         oq = ~oq;
      end
   end
   assign sym_ready = cnt_r != 2'(`BUF_DEPTH);
   assign pop = out_valid && out_ready;
   always_comb begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      if (take) begin
         mem_nxt[wp_r] = {mark, oi, oq};
         wp_nxt = ~wp_r;
      end
      if (pop) begin
         rp_nxt = ~rp_r;
      end
      cnt_nxt = cnt_r + {1'b0, take} - {1'b0, pop};
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
      mem_r <= mem_nxt;
   end

   assign out_valid = cnt_r != 2'h0;
   assign out_frame_preamble = out_valid && mem_r[rp_r][BW-1];
   assign out_i = mem_r[rp_r][2*SYM_W-1:SYM_W];
   assign out_q = mem_r[rp_r][SYM_W-1:0];

endmodule : sat_tdm_frame_sync_control
`default_nettype wire

// ==== tb/sat_tdm_frame_sync_control_properties.sv ====
// Port checks for the satellite TDM sync control
`include "sat_tdm_cfg.svh"
`default_nettype none
module sat_tdm_sync_checker #(
   parameter int SYM_W = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Register port
   input wire logic [`ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Streams
   input wire logic sym_valid,
   input wire logic sym_ready,
   input wire logic [6:0] sym_corr,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [SYM_W-1:0] out_i,
   input wire logic out_frame_preamble,
   // Enables and status
   input wire logic second_fifo_mgmt_enable,
   input wire logic first_sync_enable,
   input wire logic sync_locked
);
   // ====
   // Properties
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   a_enable_write: assert property (
      reg_wr && reg_addr == 10'h200 |=> {second_fifo_mgmt_enable, first_sync_enable} ==
      {$past(reg_wdata[7]), $past(reg_wdata[0])}) else $error("enable bits not written");
   a_take_answers: assert property (sym_valid && sym_ready |=> out_valid)
      else $error("taken symbol not presented");
   a_out_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_i))
      else $error("stalled word changed");
   a_mark_valid: assert property (out_frame_preamble |-> out_valid)
      else $error("mark without word");
   a_strong_locks: assert property (
      sym_valid && sym_ready && first_sync_enable && !sync_locked && sym_corr == 7'h7F |=> sync_locked)
      else $error("full correlation did not lock");
   a_lock_enable: assert property (!first_sync_enable |=> !sync_locked)
      else $error("lock kept while disabled");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved");
   a_unmapped_zero: assert property (reg_rd && reg_addr == 10'h3FF |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : sat_tdm_sync_checker

bind sat_tdm_frame_sync_control sat_tdm_sync_checker #(.SYM_W(SYM_W)) sat_tdm_sync_checker_i (.clock, .srst,
   .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .sym_valid, .sym_ready, .sym_corr, .out_valid,
   .out_ready, .out_i, .out_frame_preamble, .second_fifo_mgmt_enable, .first_sync_enable, .sync_locked);
`default_nettype wire

// ==== tb/sym_source.sv ====
// Soft-symbol source standing in for the demodulator
`default_nettype none
module sym_source (
   // Clock
   input wire logic clock,
   // Stream toward the block
   output logic sym_valid,
   input wire logic sym_ready,
   output logic [7:0] sym_i,
   output logic [7:0] sym_q,
   output logic [6:0] sym_corr
);
   timeunit 1ns;
   timeprecision 1ns;
   int lost = 0;
   initial begin
      sym_valid = 1'b0;
      sym_i = 8'h00;
      sym_q = 8'h00;
      sym_corr = 7'h00;
   end
   // ====
   // Word held until the edge that takes it, or for at most 50 edges
   task automatic send(input logic [7:0] i, input logic [7:0] q, input logic [6:0] c);
      logic taken;
      taken = 1'b0;
      sym_valid <= 1'b1;
      sym_i <= i;
      sym_q <= q;
      sym_corr <= c;
      for (int n = 0; n < 50 && !taken; n++) begin
         @(posedge clock);
         taken = sym_ready;
      end
      if (!taken) begin
         lost++;
      end
   endtask : send
   // Released lines show the inverse of the last word
   task automatic idle();
      sym_valid <= 1'b0;
      sym_i <= ~sym_i;
      sym_q <= ~sym_q;
      sym_corr <= ~sym_corr;
   endtask : idle
endmodule : sym_source
`default_nettype wire

// ==== tb/sat_tdm_frame_sync_control_tb.sv ====
// Self-checking bench for the satellite TDM sync control
`default_nettype none
module sat_tdm_frame_sync_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ====
   // Signals
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [9:0] reg_addr = 10'h000;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_rd = 1'b0;
   logic out_ready = 1'b1;
   logic [7:0] reg_rdata, sym_i, sym_q, out_i, out_q, en;
   logic [6:0] sym_corr;
   logic sym_valid, sym_ready, out_valid, out_frame_preamble, sync_locked;
   logic second_fifo_mgmt_enable, second_descramble_enable, second_metric_gen_enable, second_sync_enable;
   logic first_fifo_mgmt_enable, first_descramble_enable, first_metric_gen_enable, first_sync_enable;
   int fail_count = 0;
   int samples_checked = 0;
   // Address, reset value, writable mask
   logic [27:0] rt [7] = '{28'h200FFFF, 28'h204101F, 28'h2050F0F, 28'h206447F, 28'h207030F, 28'h208020F,
      28'h2090B0F};
   // Control value, expected out_i and out_q for input 12 and 34
   logic [23:0] cx [4] = '{24'h14EDCB, 24'h18EDCB, 24'h113412, 24'h123412};
   assign en = {second_fifo_mgmt_enable, second_descramble_enable, second_metric_gen_enable, second_sync_enable,
      first_fifo_mgmt_enable, first_descramble_enable, first_metric_gen_enable, first_sync_enable};
   always #50 clock = ~clock;
   sat_tdm_frame_sync_control #(.FRAME_LEN(16)) sat_tdm_frame_sync_control_i (.clock, .srst, .reg_addr, .reg_wr,
      .reg_wdata, .reg_rd, .reg_rdata, .sym_valid, .sym_ready, .sym_i, .sym_q, .sym_corr, .out_valid, .out_ready,
      .out_i, .out_q, .out_frame_preamble, .second_fifo_mgmt_enable, .second_descramble_enable,
      .second_metric_gen_enable, .second_sync_enable, .first_fifo_mgmt_enable, .first_descramble_enable,
      .first_metric_gen_enable, .first_sync_enable, .sync_locked);
   sym_source sym_source_i (.clock, .sym_valid, .sym_ready, .sym_i, .sym_q, .sym_corr);
   // ====
   // Tasks
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      chk("rdata", e, reg_rdata);
   endtask : rd
   task automatic burst(input int n, input logic [6:0] c);
      for (int k = 0; k < n; k++) begin
         sym_source_i.send(8'h12, 8'h34, c);
      end
      sym_source_i.idle();
      @(posedge clock);
   endtask : burst
   task automatic give_verdict();
      fail_count += sym_source_i.lost;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   // ====
   // Sequence
   initial begin
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      chk("enables", 8'hFF, en);
      for (int k = 0; k < 7; k++) begin
         rd(rt[k][25:16], rt[k][15:8]);
         wr(rt[k][25:16], 8'hFF);
         rd(rt[k][25:16], rt[k][7:0]);
         wr(rt[k][25:16], rt[k][15:8]);
      end
      rd(10'h3FF, 8'h00);
      wr(10'h200, 8'hA5);
      chk("enables", 8'hA5, en);
      wr(10'h200, 8'hFF);
      burst(1, 7'h43);
      chk("locked", 8'h00, 8'(sync_locked));
      out_ready <= 1'b0;
      burst(1, 7'h44);
      burst(1, 7'h00);
      chk("ready", 8'h00, 8'(sym_ready));
      chk("mark", 8'h01, 8'(out_frame_preamble));
      chk("locked", 8'h01, 8'(sync_locked));
      out_ready <= 1'b1;
      wr(10'h200, 8'hFE);
      chk("locked", 8'h00, 8'(sync_locked));
      burst(1, 7'h7F);
      chk("locked", 8'h00, 8'(sync_locked));
      wr(10'h200, 8'hFF);
      for (int k = 0; k < 4; k++) begin
         wr(10'h204, cx[k][23:16]);
         out_ready <= 1'b0;
         burst(1, 7'h00);
         chk("out_i", cx[k][15:8], out_i);
         chk("out_q", cx[k][7:0], out_q);
         out_ready <= 1'b1;
      end
      srst <= 1'b1;
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      wr(10'h205, 8'h02);
      wr(10'h208, 8'h00);
      burst(1, 7'h7F);
      burst(170, 7'h00);
      chk("locked", 8'h01, 8'(sync_locked));
      burst(16, 7'h00);
      chk("locked", 8'h00, 8'(sync_locked));
      wr(10'h208, 8'h02);
      burst(1, 7'h7F);
      rd(10'h220, 8'h01);
      burst(20, 7'h00);
      chk("locked", 8'h01, 8'(sync_locked));
      burst(16, 7'h00);
      chk("locked", 8'h00, 8'(sync_locked));
      burst(1, 7'h7F);
      for (int k = 0; k < 3; k++) begin
         burst(15, 7'h00);
         burst(1, 7'h7F);
      end
      chk("locked", 8'h01, 8'(sync_locked));
      wr(10'h204, 8'h00);
      burst(40, 7'h00);
      chk("locked", 8'h01, 8'(sync_locked));
      give_verdict();
   end
endmodule : sat_tdm_frame_sync_control_tb
`default_nettype wire
